// ==== adc_coef_banks.sv ====
// record-path coefficient banks A and B with page select and adaptive swap
// assumes APB on MCLK, FRAME_SYNC and ADC_POWERED from logic on MCLK
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adc_coef_banks (
    // clock, reset and enable
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        CE,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [31:0]      PRDATA,
    // record filter side
    input  wire logic        FRAME_SYNC,
    input  wire logic        ADC_POWERED,
    input  wire logic [7:0]  FILT_ADDR,
    output logic [23:0]      FILT_COEF,
    output logic             FILT_BANK_B,
    // interrupt
    output logic             IRQ
);
    // coefficient storage, contents undefined after reset
    logic [23:0] mem_a [0:adc_coef_pkg::BANK_DEPTH-1];
    logic [23:0] mem_b [0:adc_coef_pkg::BANK_DEPTH-1];

    adc_coef_pkg::apb_state_e state, next_state;
    logic [7:0]  page_sel, next_page_sel;
    logic        adapt_en, next_adapt_en;
    logic        bank_flag, next_bank_flag;
    logic        swap_req, next_swap_req;
    logic [1:0]  irq_status, next_irq_status;
    logic [1:0]  irq_mask, next_irq_mask;
    logic        next_pready, next_pslverr, next_irq, next_filt_bank_b;
    logic [31:0] next_prdata;
    logic [23:0] next_filt_coef, cur_word, new_word;
    logic [6:0]  reg_idx;
    logic [8:0]  cidx, fidx;
    logic [7:0]  rd_byte;
    logic        in_a, in_b, is_coef, coef_ok, denied, host_bank_b;
    logic        setup, commit, wr_en, cfg_wr, swap_now, we_a, we_b;

    // coefficient index from page offset and register index
    function automatic logic [8:0] coef_index(input logic [7:0] off, input logic [6:0] r);
        logic [6:0] rel;
        rel = r - adc_coef_pkg::REG_COEF_FIRST;
        coef_index = 9'(off[3:0] * adc_coef_pkg::COEF_PER_PAGE) + 9'(rel[6:2]);
    endfunction

    // byte lane of a coefficient, high byte first, lane 3 reads zero
    function automatic logic [7:0] get_byte(input logic [23:0] w, input logic [1:0] ln);
        case (ln)
            2'h0:    get_byte = w[23:16];
            2'h1:    get_byte = w[15:8];
            2'h2:    get_byte = w[7:0];
            default: get_byte = 8'h00;
        endcase
    endfunction

    // address decode against the current page
    always_comb
    begin
        reg_idx     = PADDR[8:2];
        in_a        = page_sel >= adc_coef_pkg::PAGE_CFG && page_sel <= adc_coef_pkg::PAGE_A_LAST;
        in_b        = page_sel >= adc_coef_pkg::PAGE_B_FIRST
                      && page_sel <= adc_coef_pkg::PAGE_B_LAST;
        is_coef     = (in_a || in_b) && reg_idx >= adc_coef_pkg::REG_COEF_FIRST;
        coef_ok     = adapt_en || !ADC_POWERED;
        denied      = is_coef && !coef_ok;
        host_bank_b = adapt_en ? !bank_flag : in_b;
        cidx        = coef_index(in_a ? page_sel - adc_coef_pkg::PAGE_CFG
                                      : page_sel - adc_coef_pkg::PAGE_B_FIRST, reg_idx);
        cur_word    = host_bank_b ? mem_b[cidx] : mem_a[cidx];
    end

    // read mux, reserved locations return zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (reg_idx == adc_coef_pkg::REG_PAGE_SEL)
            rd_byte = page_sel;
        else if (page_sel == adc_coef_pkg::PAGE_CFG && reg_idx == adc_coef_pkg::REG_CFG)
            rd_byte = {5'h00, adapt_en, bank_flag, swap_req};
        else if (page_sel == adc_coef_pkg::PAGE_IRQ && reg_idx == adc_coef_pkg::REG_IRQ_STATUS)
            rd_byte = {6'h00, irq_status};
        else if (page_sel == adc_coef_pkg::PAGE_IRQ && reg_idx == adc_coef_pkg::REG_IRQ_MASK)
            rd_byte = {6'h00, irq_mask};
        else if (is_coef && coef_ok)
            rd_byte = get_byte(cur_word, reg_idx[1:0]);
    end

    // merge a written byte into the selected coefficient
    always_comb
    begin
        new_word = cur_word;
        case (reg_idx[1:0])
            2'h0:    new_word[23:16] = PWDATA[7:0];
            2'h1:    new_word[15:8]  = PWDATA[7:0];
            2'h2:    new_word[7:0]   = PWDATA[7:0];
            default: new_word        = cur_word;
        endcase
    end

    // apb handshake: setup, one access cycle with ready high
    always_comb
    begin
        setup        = PSEL && !PENABLE;
        commit       = state == adc_coef_pkg::AT_ACCESS && PSEL && PENABLE;
        wr_en        = commit && PWRITE && !PSLVERR;
        next_state   = state;
        next_pready  = 1'b0;
        next_pslverr = PSLVERR;
        next_prdata  = PRDATA;
        case (state)
            adc_coef_pkg::AT_IDLE:
            begin
                if (setup)
                begin
                    next_state   = adc_coef_pkg::AT_ACCESS;
                    next_pready  = 1'b1;
                    next_pslverr = denied;
                    next_prdata  = (PWRITE || denied) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                end
            end
            adc_coef_pkg::AT_ACCESS:
            begin
                next_state   = adc_coef_pkg::AT_IDLE;
                next_pslverr = 1'b0;
            end
            default:
                next_state = adc_coef_pkg::AT_IDLE;
        endcase
    end

    // control registers, swap and interrupt state
    always_comb
    begin
        cfg_wr  = wr_en && page_sel == adc_coef_pkg::PAGE_CFG && reg_idx == adc_coef_pkg::REG_CFG;
        swap_now        = swap_req && adapt_en && FRAME_SYNC;
        next_page_sel   = page_sel;
        next_adapt_en   = adapt_en;
        next_bank_flag  = bank_flag ^ swap_now;
        next_swap_req   = swap_now ? 1'b0 : swap_req;
        next_irq_mask   = irq_mask;
        next_irq_status = irq_status;
        if (wr_en && reg_idx == adc_coef_pkg::REG_PAGE_SEL)
            next_page_sel = PWDATA[7:0];
        if (cfg_wr)
        begin
            next_adapt_en = PWDATA[adc_coef_pkg::BIT_ADAPT_EN];
            next_swap_req = PWDATA[adc_coef_pkg::BIT_SWAP_REQ];
        end
        if (wr_en && page_sel == adc_coef_pkg::PAGE_IRQ)
        begin
            if (reg_idx == adc_coef_pkg::REG_IRQ_STATUS)
                next_irq_status = irq_status & ~PWDATA[1:0];
            if (reg_idx == adc_coef_pkg::REG_IRQ_MASK)
                next_irq_mask = PWDATA[1:0];
        end
        // events set after the clear so a coinciding event is kept
        if (swap_now)
            next_irq_status[adc_coef_pkg::IRQ_SWAP] = 1'b1;
        if (commit && PSLVERR)
            next_irq_status[adc_coef_pkg::IRQ_DENIED] = 1'b1;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // coefficient write enables and filter read port
    always_comb
    begin
        we_a             = wr_en && is_coef && !host_bank_b && reg_idx[1:0] != 2'h3;
        we_b             = wr_en && is_coef && host_bank_b && reg_idx[1:0] != 2'h3;
        next_filt_bank_b = adapt_en && bank_flag;
        fidx             = {1'b0, FILT_ADDR};
        next_filt_coef   = next_filt_bank_b ? mem_b[fidx] : mem_a[fidx];
    end

    // control and bus state registers
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            state       <= adc_coef_pkg::AT_IDLE;
            page_sel    <= adc_coef_pkg::RST_PAGE;
            adapt_en    <= 1'b0;
            bank_flag   <= 1'b0;
            swap_req    <= 1'b0;
            irq_status  <= adc_coef_pkg::RST_IRQ;
            irq_mask    <= adc_coef_pkg::RST_IRQ;
            PREADY      <= 1'b0;
            PSLVERR     <= 1'b0;
            PRDATA      <= 32'h0000_0000;
            FILT_COEF   <= 24'h00_0000;
            FILT_BANK_B <= 1'b0;
            IRQ         <= 1'b0;
        end
        else if (CE)
        begin
            state       <= next_state;
            page_sel    <= next_page_sel;
            adapt_en    <= next_adapt_en;
            bank_flag   <= next_bank_flag;
            swap_req    <= next_swap_req;
            irq_status  <= next_irq_status;
            irq_mask    <= next_irq_mask;
            PREADY      <= next_pready;
            PSLVERR     <= next_pslverr;
            PRDATA      <= next_prdata;
            FILT_COEF   <= next_filt_coef;
            FILT_BANK_B <= next_filt_bank_b;
            IRQ         <= next_irq;
        end
    end

    // coefficient memories, no reset
    always_ff @(posedge MCLK)
    begin
        if (CE && we_a)
            mem_a[cidx] <= new_word;
        if (CE && we_b)
            mem_b[cidx] <= new_word;
    end

    // checks
    property p_page_reset;
        @(posedge MCLK) SYS_RST |=> page_sel == 8'h00 && !adapt_en && !bank_flag;
    endproperty
    a_page_reset: assert property (p_page_reset) else $error("page or config not reset");

    property p_page_write;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && wr_en && reg_idx == 7'h00) |=> page_sel == $past(PWDATA[7:0]);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page select not written");

    property p_cfg_read;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && state == adc_coef_pkg::AT_IDLE && setup && !PWRITE && page_sel == 8'h08
         && reg_idx == 7'h01) |=> PRDATA[31:3] == 29'h0 && PRDATA[2] == $past(adapt_en);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

    property p_host_b;
        @(posedge MCLK) disable iff (SYS_RST)
        (adapt_en && !bank_flag && wr_en && is_coef && reg_idx[1:0] != 2'h3) |-> we_b && !we_a;
    endproperty
    a_host_b: assert property (p_host_b) else $error("host not on bank B");

    property p_host_a;
        @(posedge MCLK) disable iff (SYS_RST)
        (adapt_en && bank_flag && wr_en && is_coef && reg_idx[1:0] != 2'h3) |-> we_a && !we_b;
    endproperty
    a_host_a: assert property (p_host_a) else $error("host not on bank A");

    property p_no_swap;
        @(posedge MCLK) disable iff (SYS_RST) !(swap_req && adapt_en && FRAME_SYNC) |=> $stable(bank_flag);
    endproperty
    a_no_swap: assert property (p_no_swap) else $error("banks swapped without request");

    property p_swap;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && swap_now && !cfg_wr) |=> bank_flag != $past(bank_flag) && !swap_req && irq_status[0];
    endproperty
    a_swap: assert property (p_swap) else $error("swap not carried out");

    property p_denied;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && state == adc_coef_pkg::AT_IDLE && setup && denied) |=> PREADY && PSLVERR && PRDATA == 32'h0;
    endproperty
    a_denied: assert property (p_denied) else $error("coefficient access not refused");

    property p_reserved;
        @(posedge MCLK) disable iff (SYS_RST)
        (CE && state == adc_coef_pkg::AT_IDLE && setup && in_a && reg_idx > 7'h01
         && reg_idx < 7'h08) |=> PRDATA == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved register not zero");

    property p_filt_bank;
        @(posedge MCLK) disable iff (SYS_RST) (CE && !adapt_en) |=> !FILT_BANK_B;
    endproperty
    a_filt_bank: assert property (p_filt_bank) else $error("filter off bank A");

    property p_irq;
        @(posedge MCLK) disable iff (SYS_RST) IRQ == |(irq_status & irq_mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// ==== adc_coef_pkg.sv ====
// constants for the record-path coefficient bank register block
// assumes an APB master with byte addresses, one byte register per word
package adc_coef_pkg;
    // pages served by the block
    localparam logic [7:0] PAGE_CFG     = 8'h08;
    localparam logic [7:0] PAGE_A_LAST  = 8'h10;
    localparam logic [7:0] PAGE_B_FIRST = 8'h1a;
    localparam logic [7:0] PAGE_B_LAST  = 8'h22;
    localparam logic [7:0] PAGE_IRQ     = 8'hff;
    // register indices inside a page
    localparam logic [6:0] REG_PAGE_SEL   = 7'h00;
    localparam logic [6:0] REG_CFG        = 7'h01;
    localparam logic [6:0] REG_COEF_FIRST = 7'h08;
    localparam logic [6:0] REG_IRQ_STATUS = 7'h01;
    localparam logic [6:0] REG_IRQ_MASK   = 7'h02;
    // configuration register fields
    localparam int BIT_SWAP_REQ  = 0;
    localparam int BIT_BANK_FLAG = 1;
    localparam int BIT_ADAPT_EN  = 2;
    // interrupt status fields
    localparam int IRQ_SWAP   = 0;
    localparam int IRQ_DENIED = 1;
    // reset values
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [1:0] RST_IRQ  = 2'h0;
    // storage shape: nine pages of thirty coefficients per bank
    localparam logic [8:0] COEF_PER_PAGE = 9'h01e;
    localparam int         BANK_DEPTH    = 270;
    localparam int         COEF_W        = 24;
    // apb slave phases
    typedef enum logic [0:0] {
        AT_IDLE   = 1'b0,
        AT_ACCESS = 1'b1
    } apb_state_e;
endpackage

// ==== adc_coef_banks_unused_marker.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== frame_source.sv ====
// frame boundary source standing in for the record filter timing
// assumes the block's clock and its synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module frame_source #(parameter int FRAME_LEN = 16) (
    // clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    // one-cycle frame boundary pulse
    output logic      frame_sync
);
    int cnt;
    // one pulse per frame while running, silent otherwise
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            cnt        <= 0;
            frame_sync <= 1'b0;
        end
        else
        begin
            cnt        <= (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
            frame_sync <= (cnt == FRAME_LEN - 1);
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the record coefficient banks
// assumes an APB master here and the frame source as partner
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pwr = 0, run = 0, ce = 1;
    logic [31:0] paddr = '0, pwdata = '0, rd;
    logic [7:0]  filt_addr = '0;
    logic        pready, pslverr, frame_sync, filt_bank_b, irq;
    logic [31:0] prdata;
    logic [23:0] filt_coef, v, ma [0:255], mb [0:255];
    int          n_errors = 0, check_count = 0;

    // device and partner
    adc_coef_banks adc_coef_banks_inst (.MCLK(mclk), .SYS_RST(sys_rst), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PSLVERR(pslverr), .PRDATA(prdata), .FRAME_SYNC(frame_sync), .ADC_POWERED(pwr),
        .FILT_ADDR(filt_addr), .FILT_COEF(filt_coef), .FILT_BANK_B(filt_bank_b), .IRQ(irq));
    frame_source frame_source_inst (.clk(mclk), .rst(sys_rst), .run(run),
        .frame_sync(frame_sync));

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                       input logic err);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {23'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // read one register and compare its byte
    task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00, 1'b0);
        chk(what, {24'h0, exp}, rd);
    endtask

    // write a coefficient, high byte first
    task automatic cw(input logic [7:0] pg, input int s, input logic [23:0] c);
        apb(1'b1, 7'h00, pg, 1'b0);
        for (int i = 0; i < 3; i++)
            apb(1'b1, 7'(8 + 4 * s + i), c[23 - 8 * i -: 8], 1'b0);
    endtask

    // read a coefficient back, reserved fourth byte reads zero
    task automatic cr(input logic [7:0] pg, input int s, input logic [23:0] c);
        apb(1'b1, 7'h00, pg, 1'b0);
        for (int i = 0; i < 4; i++)
            rdchk(7'(8 + 4 * s + i), (i == 3) ? 8'h00 : c[23 - 8 * i -: 8], "coef byte");
    endtask

    // present a filter address and check bank and coefficient
    task automatic fchk(input logic [7:0] a, input logic b, input logic [23:0] c);
        @(posedge mclk);
        filt_addr <= a;
        repeat (2) @(posedge mclk);
        chk("filt_bank_b", {31'h0, b}, {31'h0, filt_bank_b});
        chk("filt_coef", {8'h00, c}, {8'h00, filt_coef});
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        conclude();
    end

    // main sequence
    initial
    begin
        void'($urandom(71));
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rdchk(7'h00, 8'h00, "page sel reset");
        apb(1'b1, 7'h00, 8'h08, 1'b0);
        rdchk(7'h01, 8'h00, "config reset");
        v = 24'($urandom);
        apb(1'b1, 7'h00, v[7:0], 1'b0);
        rdchk(7'h00, v[7:0], "page sel");
        // channel off, adaptive off: every bank page is reachable
        for (int s = 0; s < 3; s++)
        begin
            ma[s] = 24'($urandom);
            cw(8'h08, s, ma[s]);
            ma[30 + s] = 24'($urandom);
            cw(8'h09, s, ma[30 + s]);
            mb[s] = 24'($urandom);
            cw(8'h1a, s, mb[s]);
        end
        ma[240] = 24'($urandom);
        cw(8'h10, 0, ma[240]);
        for (int s = 0; s < 3; s++)
        begin
            cr(8'h08, s, ma[s]);
            cr(8'h09, s, ma[30 + s]);
            cr(8'h1a, s, mb[s]);
        end
        cr(8'h10, 0, ma[240]);
        apb(1'b1, 7'h03, 8'h00, 1'b0);
        rdchk(7'h03, 8'h00, "reserved");
        apb(1'b1, 7'h00, 8'h05, 1'b0);
        rdchk(7'h08, 8'h00, "unmapped");
        fchk(8'd0, 1'b0, ma[0]);
        fchk(8'd31, 1'b0, ma[31]);
        // clock enable low holds every flop, filter port included
        ce        <= 1'b0;
        filt_addr <= 8'd0;
        repeat (3) @(posedge mclk);
        chk("frozen coef", {8'h00, ma[31]}, {8'h00, filt_coef});
        ce        <= 1'b1;
        // channel running with adaptive off: access refused, data kept
        pwr <= 1'b1;
        apb(1'b1, 7'h00, 8'h1a, 1'b0);
        apb(1'b0, 7'h08, 8'h00, 1'b1);
        chk("refused read", 32'h0000_0000, rd);
        apb(1'b1, 7'h08, ~mb[0][23:16], 1'b1);
        pwr <= 1'b0;
        rdchk(7'h08, mb[0][23:16], "dropped write");
        // refusal interrupt: raise, unmask, clear
        apb(1'b1, 7'h00, adc_coef_pkg::PAGE_IRQ, 1'b0);
        rdchk(adc_coef_pkg::REG_IRQ_STATUS, 8'h02, "irq status");
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        apb(1'b1, adc_coef_pkg::REG_IRQ_MASK, 8'h03, 1'b0);
        repeat (2) @(posedge mclk);
        chk("irq on", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, adc_coef_pkg::REG_IRQ_STATUS, 8'h02, 1'b0);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        // adaptive on: host reaches bank B, filter stays on bank A
        apb(1'b1, 7'h00, 8'h08, 1'b0);
        apb(1'b1, 7'h01, 8'h04, 1'b0);
        pwr <= 1'b1;
        run <= 1'b1;
        mb[1] = 24'($urandom);
        cw(8'h08, 1, mb[1]);
        cr(8'h1a, 1, mb[1]);
        fchk(8'd1, 1'b0, ma[1]);
        repeat (40) @(posedge mclk);
        apb(1'b1, 7'h00, 8'h08, 1'b0);
        rdchk(7'h01, 8'h04, "no swap");
        // swap request self clears at a frame boundary and the flag toggles
        apb(1'b1, 7'h01, 8'h05, 1'b0);
        do
            apb(1'b0, 7'h01, 8'h00, 1'b0);
        while (rd[0] !== 1'b0 && check_count < 100000);
        chk("config swapped", 32'h0000_0006, rd);
        fchk(8'd1, 1'b1, mb[1]);
        cr(8'h1a, 1, ma[1]);
        // host writes now land in bank A while the filter stays on bank B
        ma[2] = 24'($urandom);
        cw(8'h1a, 2, ma[2]);
        cr(8'h08, 2, ma[2]);
        fchk(8'd2, 1'b1, mb[2]);
        apb(1'b1, 7'h00, adc_coef_pkg::PAGE_IRQ, 1'b0);
        rdchk(adc_coef_pkg::REG_IRQ_STATUS, 8'h01, "swap status");
        run <= 1'b0;
        conclude();
    end
endmodule
`default_nettype wire
